// *** rtl/plc_pkg.sv ***
// Package: constants and carrier types for the pulse-count current loader
package plc_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned LATCH_TIMEOUT_NS = 500000;
    localparam int unsigned OFF_TIMEOUT_NS = 500000;
    // Longest times round down to whole cycles
    localparam int unsigned LATCH_CYCLES = (LATCH_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned OFF_CYCLES = (OFF_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;

    // ****************************************
    // Edge counts and addresses
    // ****************************************
    localparam logic [4:0] DATA_MIN_EDGES = 5'h01;
    localparam logic [4:0] DATA_MAX_EDGES = 5'h10;
    localparam logic [4:0] ADDR_BASE_EDGES = 5'h11;
    localparam logic [4:0] ADDR_LAST_EDGES = 5'h15;
    localparam logic [4:0] EDGE_SAT = 5'h1F;
    localparam logic [2:0] ADDR_BOTH = 3'h0;
    localparam logic [2:0] ADDR_BANK_ONE = 3'h1;
    localparam logic [2:0] ADDR_BANK_TWO = 3'h2;
    localparam logic [2:0] ADDR_FULL_SCALE = 3'h3;
    localparam logic [2:0] ADDR_LOW = 3'h4;
    localparam logic [2:0] ADDR_RESET = 3'h0;

    // ****************************************
    // Register indexes and values
    // ****************************************
    localparam int REG_BANK_ONE = 0;
    localparam int REG_BANK_TWO = 1;
    localparam int REG_FULL_SCALE = 2;
    localparam int REG_LOW = 3;
    localparam int NUM_REGS = 4;
    localparam logic [3:0] REG_RESET = 4'h0;
    localparam logic [3:0] CODE_NO_CURRENT = 4'h0;
    localparam logic [3:0] FS_18MA = 4'h1;
    localparam logic [3:0] FS_27MA = 4'h2;
    localparam logic [3:0] FS_14MA = 4'h3;
    localparam logic [3:0] FS_LOW = 4'h4;

    typedef enum logic [1:0] {
        PLC_SCALE_18 = 2'b00,
        PLC_SCALE_27 = 2'b01,
        PLC_SCALE_14 = 2'b10
    } plc_scale_t;

    typedef enum logic {
        PLC_OFF = 1'b0,
        PLC_ON = 1'b1
    } plc_state_t;

    typedef struct packed {
        logic [3:0] bank_one;
        logic [3:0] bank_two;
        logic [3:0] full_scale;
        logic [3:0] low_level;
    } plc_regs_t;

    typedef struct packed {
        logic low_mode;
        plc_scale_t scale;
        logic bank_one_on;
        logic bank_two_on;
        logic [3:0] bank_one_step;
        logic [3:0] bank_two_step;
        logic [1:0] low_step;
    } plc_sink_t;

    typedef struct packed {
        logic is_data;
        logic is_addr;
        logic [2:0] addr;
    } plc_kind_t;

endpackage

// *** rtl/plc_pin_sync.sv ***
// Two-stage synchroniser and rising-edge detector for the control pin
`timescale 1ns/1ps
module plc_pin_sync (
    input wire logic clock,  // System clock
    input wire logic rst,    // Async reset, active high
    input wire logic pin,    // Raw control pin
    output logic level,      // Synchronised pin level
    output logic rise        // One-cycle pulse on a rising edge
);
    logic [1:0] sync_ff;
    logic prev_ff;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync_ff <= 2'h0;
        end else begin
            sync_ff <= {sync_ff[0], pin};
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= sync_ff[1];
        end
    end

    assign level = sync_ff[1];
    assign rise = sync_ff[1] & ~prev_ff;
endmodule

// *** rtl/plc_sink_decode.sv ***
// Maps the four stored registers to sink-bank enables, scale and steps
`timescale 1ns/1ps
module plc_sink_decode (
    input plc_pkg::plc_regs_t regs,   // Stored register contents
    output plc_pkg::plc_sink_t sink   // Decoded sink control
);
    import plc_pkg::*;

    logic [3:0] low_v;
    logic low;

    assign low = (regs.full_scale == FS_LOW);
    // Data 16 is stored as 0 and wraps to 15 here
    assign low_v = regs.low_level - 4'h1;

    always_comb begin
        sink = '0;
        case (regs.full_scale)
            FS_27MA: sink.scale = PLC_SCALE_27;
            FS_14MA: sink.scale = PLC_SCALE_14;
            default: sink.scale = PLC_SCALE_18;
        endcase
        sink.low_mode = low;
        if (low) begin
            sink.bank_one_on = low_v[3];
            sink.bank_two_on = low_v[2];
            sink.low_step = low_v[1:0];
        end else begin
            sink.bank_one_on = (regs.bank_one != CODE_NO_CURRENT);
            sink.bank_two_on = (regs.bank_two != CODE_NO_CURRENT);
            // A bank that is off shows step 0, so cleared registers give all-zero
            if (sink.bank_one_on) begin
                sink.bank_one_step = regs.bank_one - 4'h1;
            end
            if (sink.bank_two_on) begin
                sink.bank_two_step = regs.bank_two - 4'h1;
            end
        end
    end
endmodule

// *** rtl/plc_loader.sv ***
// Pulse-count control pin decoder that loads the sink current registers
`timescale 1ns/1ps
module plc_loader #(
    parameter int unsigned LATCH_CYCLES = plc_pkg::LATCH_CYCLES,
    parameter int unsigned OFF_CYCLES = plc_pkg::OFF_CYCLES
) (
    input wire logic clock,                // System clock, 200 MHz
    input wire logic rst,                  // Async reset, active high
    input wire logic ctrl_pin,             // Single-wire control pin
    output plc_pkg::plc_sink_t sink_ctrl,  // Registered sink control
    output logic active                    // Registered device-enabled flag
);
    import plc_pkg::*;

    localparam int LW = $clog2(LATCH_CYCLES + 1);
    localparam int OW = $clog2(OFF_CYCLES + 1);
    localparam logic [LW-1:0] LAT_LAST = LW'(LATCH_CYCLES - 1);
    localparam logic [OW-1:0] OFF_LAST = OW'(OFF_CYCLES - 1);

    // ****************************************
    // Decoding helpers
    // ****************************************
    function automatic plc_kind_t classify(input logic [4:0] n);
        plc_kind_t k;
        k.is_data = (n >= DATA_MIN_EDGES) && (n <= DATA_MAX_EDGES);
        k.is_addr = (n >= ADDR_BASE_EDGES) && (n <= ADDR_LAST_EDGES);
        k.addr = 3'(n - ADDR_BASE_EDGES);
        return k;
    endfunction

    function automatic logic hits(input logic [2:0] a, input int idx);
        logic h;
        h = 1'b0;
        case (a)
            ADDR_BOTH: h = (idx == REG_BANK_ONE) || (idx == REG_BANK_TWO);
            ADDR_BANK_ONE: h = (idx == REG_BANK_ONE);
            ADDR_BANK_TWO: h = (idx == REG_BANK_TWO);
            ADDR_FULL_SCALE: h = (idx == REG_FULL_SCALE);
            ADDR_LOW: h = (idx == REG_LOW);
            default: h = 1'b0;
        endcase
        return h;
    endfunction

    // ****************************************
    // Pin sampling
    // ****************************************
    logic pin_high;
    logic pin_rise;

    plc_pin_sync u_sync (
        .clock(clock),
        .rst(rst),
        .pin(ctrl_pin),
        .level(pin_high),
        .rise(pin_rise)
    );

    // ****************************************
    // State and timers
    // ****************************************
    plc_state_t state_ff;
    logic [4:0] edge_cnt_ff;
    logic [LW-1:0] hi_cnt_ff;
    logic [OW-1:0] lo_cnt_ff;
    logic [2:0] addr_ff;
    logic [3:0] reg_ff [NUM_REGS];
    plc_sink_t sink_ff;
    plc_regs_t regs;
    plc_sink_t nxt_sink;
    plc_kind_t kind;
    logic latch_now;
    logic off_now;

    assign kind = classify(edge_cnt_ff);
    assign latch_now = pin_high && !pin_rise && (edge_cnt_ff != 5'h00)
        && (hi_cnt_ff == LAT_LAST);
    assign off_now = !pin_high && (lo_cnt_ff == OFF_LAST) && (state_ff == PLC_ON);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= PLC_OFF;
        end else begin
            case (state_ff)
                PLC_OFF: begin
                    if (pin_rise) begin
                        state_ff <= PLC_ON;
                    end
                end
                PLC_ON: begin
                    if (off_now) begin
                        state_ff <= PLC_OFF;
                    end
                end
                default: state_ff <= PLC_OFF;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            edge_cnt_ff <= 5'h00;
        end else if (latch_now || off_now) begin
            edge_cnt_ff <= 5'h00;
        end else if (pin_rise && edge_cnt_ff != EDGE_SAT) begin
            edge_cnt_ff <= edge_cnt_ff + 5'h01;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hi_cnt_ff <= '0;
        end else if (!pin_high || pin_rise || latch_now) begin
            hi_cnt_ff <= '0;
        end else if (edge_cnt_ff != 5'h00) begin
            hi_cnt_ff <= hi_cnt_ff + LW'(1);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lo_cnt_ff <= '0;
        end else if (pin_high) begin
            lo_cnt_ff <= '0;
        end else if (lo_cnt_ff != OFF_LAST) begin
            lo_cnt_ff <= lo_cnt_ff + OW'(1);
        end
    end

    // ****************************************
    // Address and data registers
    // ****************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            addr_ff <= ADDR_RESET;
        end else if (off_now) begin
            addr_ff <= ADDR_RESET;
        end else if (latch_now && kind.is_addr) begin
            addr_ff <= kind.addr;
        end
    end

    generate
        for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    reg_ff[i] <= REG_RESET;
                end else if (off_now) begin
                    reg_ff[i] <= REG_RESET;
                end else if (latch_now && kind.is_data && hits(addr_ff, i)) begin
                    reg_ff[i] <= edge_cnt_ff[3:0];
                end
            end
        end
    endgenerate

    // ****************************************
    // Sink control output
    // ****************************************
    assign regs.bank_one = reg_ff[REG_BANK_ONE];
    assign regs.bank_two = reg_ff[REG_BANK_TWO];
    assign regs.full_scale = reg_ff[REG_FULL_SCALE];
    assign regs.low_level = reg_ff[REG_LOW];

    plc_sink_decode u_decode (
        .regs(regs),
        .sink(nxt_sink)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sink_ff <= '0;
        end else begin
            sink_ff <= nxt_sink;
        end
    end

    assign sink_ctrl = sink_ff;
    assign active = (state_ff == PLC_ON);

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    logic [3:0] low_v;
    assign low_v = reg_ff[REG_LOW] - 4'h1;

    sequence s_data_at(logic [2:0] a);
        latch_now && kind.is_data && (addr_ff == a);
    endsequence

    property p_edge_count;
        pin_rise && !latch_now && !off_now && (edge_cnt_ff != EDGE_SAT)
            |=> edge_cnt_ff == $past(edge_cnt_ff) + 5'h01;
    endproperty
    a_edge_count: assert property (p_edge_count)
        else $error("rising edge not counted");

    property p_latch_clear;
        latch_now |=> (edge_cnt_ff == 5'h00) && (hi_cnt_ff == '0);
    endproperty
    a_latch_clear: assert property (p_latch_clear)
        else $error("burst not cleared after latch");

    property p_addr_select;
        latch_now && (edge_cnt_ff >= ADDR_BASE_EDGES) && (edge_cnt_ff <= ADDR_LAST_EDGES)
            |=> addr_ff == 3'($past(edge_cnt_ff) - 5'h11);
    endproperty
    a_addr_select: assert property (p_addr_select)
        else $error("address not taken from edge count");

    property p_both;
        s_data_at(ADDR_BOTH) |=> (reg_ff[REG_BANK_ONE] == $past(edge_cnt_ff[3:0]))
            && (reg_ff[REG_BANK_TWO] == $past(edge_cnt_ff[3:0]));
    endproperty
    a_both: assert property (p_both)
        else $error("address 0 did not load both banks");

    property p_bank_one;
        s_data_at(ADDR_BANK_ONE) |=> (reg_ff[REG_BANK_ONE] == $past(edge_cnt_ff[3:0]))
            && $stable(reg_ff[REG_BANK_TWO]);
    endproperty
    a_bank_one: assert property (p_bank_one)
        else $error("address 1 write wrong");

    property p_bank_two;
        s_data_at(ADDR_BANK_TWO) |=> (reg_ff[REG_BANK_TWO] == $past(edge_cnt_ff[3:0]))
            && $stable(reg_ff[REG_BANK_ONE]);
    endproperty
    a_bank_two: assert property (p_bank_two)
        else $error("address 2 write wrong");

    property p_addr_kept;
        latch_now && (edge_cnt_ff <= DATA_MAX_EDGES) |=> $stable(addr_ff);
    endproperty
    a_addr_kept: assert property (p_addr_kept)
        else $error("data burst changed the address");

    property p_big_is_addr;
        latch_now && (edge_cnt_ff > DATA_MAX_EDGES)
            |=> $stable(reg_ff[REG_BANK_ONE]) && $stable(reg_ff[REG_LOW]);
    endproperty
    a_big_is_addr: assert property (p_big_is_addr)
        else $error("count above 16 written as data");

    property p_discard;
        latch_now && (edge_cnt_ff > ADDR_LAST_EDGES)
            |=> $stable(addr_ff) && $stable(reg_ff[REG_FULL_SCALE]);
    endproperty
    a_discard: assert property (p_discard)
        else $error("undefined count changed state");

    property p_shutdown;
        off_now |=> !active && (addr_ff == ADDR_RESET) && (reg_ff[REG_BANK_ONE] == REG_RESET)
            && (reg_ff[REG_BANK_TWO] == REG_RESET) && (reg_ff[REG_LOW] == REG_RESET);
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("shutdown did not clear state");

    property p_low_mode;
        ##1 sink_ctrl.low_mode == $past(reg_ff[REG_FULL_SCALE] == FS_LOW);
    endproperty
    a_low_mode: assert property (p_low_mode)
        else $error("low mode does not follow full-scale register");

    property p_low_enables;
        ##1 $past(reg_ff[REG_FULL_SCALE] == FS_LOW) |-> (sink_ctrl.bank_one_on == $past(low_v[3]))
            && (sink_ctrl.bank_two_on == $past(low_v[2])) && (sink_ctrl.low_step == $past(low_v[1:0]));
    endproperty
    a_low_enables: assert property (p_low_enables)
        else $error("low-current decode wrong");
endmodule

// *** verification/plc_host_model.sv ***
// Host model that drives pulse-count bursts onto the control pin
`timescale 1ns/1ps
module plc_host_model (
    input wire logic clock,  // System clock
    output logic ctrl_pin    // Control pin toward the loader
);
    // ****************************************
    // Pin drive
    // ****************************************
    initial ctrl_pin = 1'b0;

    task automatic send(input int edges, input int pause);
        for (int i = 0; i < edges; i++) begin
            repeat (2) @(posedge clock) ctrl_pin <= 1'b0;
            repeat (2) @(posedge clock) ctrl_pin <= 1'b1;
        end
        repeat (pause) @(posedge clock);
    endtask

    task automatic go_low(input int cycles);
        @(posedge clock) ctrl_pin <= 1'b0;
        repeat (cycles) @(posedge clock);
    endtask
endmodule

// *** verification/pulse_count_led_current_loader_test.sv ***
// Self-checking bench for the pulse-count current loader
`timescale 1ns/1ps
module pulse_count_led_current_loader_test;
    import plc_pkg::*;
    localparam int unsigned LAT = 20;
    localparam int unsigned OFF = 40;
    logic clock;
    logic rst;
    logic ctrl_pin;
    plc_sink_t sink_ctrl;
    logic active;
    int failures;
    int comparisons;
    logic [3:0] regs_m [NUM_REGS];
    logic [2:0] addr_m;

    plc_loader #(.LATCH_CYCLES(LAT), .OFF_CYCLES(OFF)) u_plc_loader (
        .clock(clock), .rst(rst), .ctrl_pin(ctrl_pin),
        .sink_ctrl(sink_ctrl), .active(active));
    plc_host_model u_plc_host_model (.clock(clock), .ctrl_pin(ctrl_pin));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // ****************************************
    // Expected behaviour
    // ****************************************
    function automatic plc_sink_t exp_sink();
        plc_sink_t s;
        logic [3:0] v;
        s = '0;
        v = regs_m[REG_LOW] - 4'h1;
        if (regs_m[REG_FULL_SCALE] == FS_LOW) begin
            s.low_mode = 1'b1;
            s.bank_one_on = v[3];
            s.bank_two_on = v[2];
            s.low_step = v[1:0];
        end else begin
            case (regs_m[REG_FULL_SCALE])
                FS_27MA: s.scale = PLC_SCALE_27;
                FS_14MA: s.scale = PLC_SCALE_14;
                default: s.scale = PLC_SCALE_18;
            endcase
            s.bank_one_on = (regs_m[REG_BANK_ONE] != CODE_NO_CURRENT);
            s.bank_two_on = (regs_m[REG_BANK_TWO] != CODE_NO_CURRENT);
            if (s.bank_one_on) s.bank_one_step = regs_m[REG_BANK_ONE] - 4'h1;
            if (s.bank_two_on) s.bank_two_step = regs_m[REG_BANK_TWO] - 4'h1;
        end
        return s;
    endfunction

    function automatic void apply(input int n);
        logic [3:0] d;
        d = 4'(n);
        if (n >= 1 && n <= 16) begin
            if (addr_m == ADDR_BOTH || addr_m == ADDR_BANK_ONE) regs_m[REG_BANK_ONE] = d;
            if (addr_m == ADDR_BOTH || addr_m == ADDR_BANK_TWO) regs_m[REG_BANK_TWO] = d;
            if (addr_m == ADDR_FULL_SCALE) regs_m[REG_FULL_SCALE] = d;
            if (addr_m == ADDR_LOW) regs_m[REG_LOW] = d;
        end else if (n >= 17 && n <= 21) begin
            addr_m = 3'(n - 17);
        end
    endfunction

    function automatic void clear_model();
        foreach (regs_m[i]) regs_m[i] = REG_RESET;
        addr_m = ADDR_RESET;
    endfunction

    // ****************************************
    // Compare and report
    // ****************************************
    task automatic check_sink(input plc_sink_t exp, input plc_sink_t seen);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected sink_ctrl expected %h seen %h", exp, seen);
        end
    endtask

    task automatic check_bit(input string name, input logic exp, input logic seen);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %b seen %b", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // Transfers
    // ****************************************
    task automatic burst(input int n);
        u_plc_host_model.send(n, LAT + 8);
        apply(n);
        #1;
        check_sink(exp_sink(), sink_ctrl);
    endtask

    task automatic shutdown();
        u_plc_host_model.go_low(OFF + 8);
        clear_model();
        #1;
        check_bit("active", 1'b0, active);
        check_sink(exp_sink(), sink_ctrl);
    endtask

    // Cuts a hung run short
    initial begin
        repeat (100000) @(posedge clock);
        failures++;
        results();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(4963));
        failures = 0;
        comparisons = 0;
        clear_model();
        rst = 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        #1;
        check_sink(exp_sink(), sink_ctrl);
        check_bit("active", 1'b0, active);
        burst(2 + $urandom_range(13));
        check_bit("active", 1'b1, active);
        for (int a = 17; a <= 19; a++) begin
            burst(a);
            burst(1 + $urandom_range(14));
            burst(1 + $urandom_range(14));
            burst(16);
            burst(15);
        end
        burst(20);
        for (int d = 1; d <= 3; d++) begin
            burst(d);
        end
        burst(21);
        burst(9);
        burst(20);
        burst(4);
        burst(21);
        for (int d = 1; d <= 16; d++) begin
            burst(d);
        end
        burst(20);
        burst(2);
        burst(22);
        burst(25);
        for (int i = 0; i < 16; i++) begin
            burst(1 + $urandom_range(24));
        end
        shutdown();
        burst(1 + $urandom_range(14));
        check_bit("active", 1'b1, active);
        results();
    end
endmodule
